// File: ivr_defs.vh
`ifndef IVR_DEFS_VH
`define IVR_DEFS_VH

`define IVR_ADDR_W 20
`define IVR_INFO_ADDR 20'h00000
`define IVR_FIX_UNDEF 20'hfffdc
`define IVR_FIX_OVF 20'hfffe0
`define IVR_FIX_BREAK 20'hfffe4
`define IVR_FIX_AMATCH 20'hfffe8
`define IVR_FIX_STEP 20'hfffec
`define IVR_FIX_WDT 20'hffff0
`define IVR_FIX_DBG 20'hffff4
`define IVR_FIX_NMI 20'hffff8
`define IVR_FIX_RESET 20'hffffc
`define IVR_FIX_LAST 20'hfffff
`define IVR_BREAK_SEL_ADDR 20'hfffe7
`define IVR_BREAK_SEL_VAL 8'hff
`define IVR_ENTRY_BYTES 3'h4
`define IVR_TABLE_BYTES 9'h100
`define IVR_NUM_BREAK 6'h00
`define IVR_NUM_SW_UNMASKED 6'h20
`define IVR_NUM_CH2_COLL 6'h0a
`define IVR_NUM_CH2_TX 6'h0f
`define IVR_NUM_CH2_RX 6'h10
`define IVR_NUM_EXT5 6'h08
`define IVR_NUM_EXT4 6'h09

`define IVR_SRC_UNDEF 4'h0
`define IVR_SRC_OVF 4'h1
`define IVR_SRC_BREAK 4'h2
`define IVR_SRC_AMATCH 4'h3
`define IVR_SRC_STEP 4'h4
`define IVR_SRC_WDT 4'h5
`define IVR_SRC_OSC 4'h6
`define IVR_SRC_VDROP 4'h7
`define IVR_SRC_DBG 4'h8
`define IVR_SRC_NMI 4'h9
`define IVR_SRC_RESET 4'ha

`endif

// File: ivr_fixed_map.v
`timescale 1ns/100ps
`default_nettype none
`include "ivr_defs.vh"

module ivr_fixed_map (
  input wire [3:0] src,
  output reg [19:0] entry_addr,
  output reg src_valid
);

  always @* begin
    src_valid = 1'b1;
    case (src)
      `IVR_SRC_UNDEF: entry_addr = `IVR_FIX_UNDEF;
      `IVR_SRC_OVF: entry_addr = `IVR_FIX_OVF;
      `IVR_SRC_BREAK: entry_addr = `IVR_FIX_BREAK;
      `IVR_SRC_AMATCH: entry_addr = `IVR_FIX_AMATCH;
      `IVR_SRC_STEP: entry_addr = `IVR_FIX_STEP;
      `IVR_SRC_WDT, `IVR_SRC_OSC, `IVR_SRC_VDROP: entry_addr = `IVR_FIX_WDT;
      `IVR_SRC_DBG: entry_addr = `IVR_FIX_DBG;
      `IVR_SRC_NMI: entry_addr = `IVR_FIX_NMI;
      `IVR_SRC_RESET: entry_addr = `IVR_FIX_RESET;
      default: begin
        entry_addr = `IVR_FIX_RESET;
        src_valid = 1'b0;
      end
    endcase
  end

endmodule // ivr_fixed_map
`default_nettype wire

// File: ivr_ch2_source.v
`timescale 1ns/100ps
`default_nettype none
`include "ivr_defs.vh"

module ivr_ch2_source (
  input wire clk,
  input wire rst_n,
  input wire i2c_mode,
  input wire ch2_tx_evt,
  input wire ch2_rx_evt,
  input wire ch2_not_acknowledge,
  input wire ch2_acknowledge,
  input wire ch2_collision_evt,
  input wire ch2_start_stop_evt,
  output reg raise_tx_ff,
  output reg raise_rx_ff,
  output reg raise_coll_ff
);

  wire nxt_raise_tx;
  wire nxt_raise_rx;
  wire nxt_raise_coll;

  // Bus mode swaps the event that drives each shared entry
  assign nxt_raise_tx = i2c_mode ? ch2_not_acknowledge : ch2_tx_evt;
  assign nxt_raise_rx = i2c_mode ? ch2_acknowledge : ch2_rx_evt;
  assign nxt_raise_coll = i2c_mode ? ch2_start_stop_evt : ch2_collision_evt;

  always @(posedge clk) begin
    if (!rst_n) begin
      raise_tx_ff <= 1'b0;
      raise_rx_ff <= 1'b0;
      raise_coll_ff <= 1'b0;
    end else begin
      raise_tx_ff <= nxt_raise_tx;
      raise_rx_ff <= nxt_raise_rx;
      raise_coll_ff <= nxt_raise_coll;
    end
  end

endmodule // ivr_ch2_source
`default_nettype wire

// File: ivr_resolver.v
// Summary of operation
// - Every vector entry is four consecutive bytes holding a routine start address.
// - On acceptance the fetched routine address is loaded into the program counter.
// - Fixed entries occupy FFFDC through FFFFF, one four-byte entry per source, except that watchdog, oscillator and voltage share one.
// - Undefined-opcode trap vectors through FFFDC, lowest fixed entry.
// - Overflow FFFE0, break FFFE4, address match FFFE8, single step FFFEC.
// - Break uses relocatable entry zero when byte FFFE7 reads FF.
// - Watchdog, oscillator and voltage share FFFF0; debugger FFFF4, NMI FFFF8, reset FFFFC.
// - High bytes of fixed entries are exported to the flash ID check.
// - Relocatable table is 256 bytes starting at the vector table base.
// - Even base is fast; odd base works but needs more reads.
// - Number n sits at base plus 4n to 4n+3; break is number zero.
// - Break and software numbers 32 to 63 ignore the global enable.
// - In I2C mode entries 15 and 16 come from not-ack and ack.
// - Number 10 is bus collision, or start/stop detection in I2C mode.
// - Sequence starts by reading address 00000, then clears the source request.
`timescale 1ns/100ps
`default_nettype none
`include "ivr_defs.vh"

module ivr_resolver #(
  parameter AW = `IVR_ADDR_W
) (
  input wire clk,
  input wire rst_n,
  input wire req_valid,
  input wire req_fixed,
  input wire [3:0] req_src,
  input wire [5:0] req_num,
  input wire req_hw,
  input wire global_int_enable,
  input wire [AW-1:0] vector_table_base,
  input wire mem_rd_valid,
  input wire [15:0] mem_rd_data,
  input wire i2c_mode,
  input wire ch2_tx_evt,
  input wire ch2_rx_evt,
  input wire ch2_not_acknowledge,
  input wire ch2_acknowledge,
  input wire ch2_collision_evt,
  input wire ch2_start_stop_evt,
  output reg req_ready_ff,
  output reg req_refused_ff,
  output reg mem_rd_en_ff,
  output reg [AW-1:0] mem_addr_ff,
  output reg mem_word_ff,
  output reg [15:0] info_ff,
  output reg clear_req_ff,
  output reg [5:0] clear_num_ff,
  output reg pc_load_ff,
  output reg [AW-1:0] pc_value_ff,
  output reg id_byte_stb_ff,
  output reg [7:0] id_byte_ff,
  output wire raise_ch2_tx_ff,
  output wire raise_ch2_rx_ff,
  output wire raise_ch2_coll_ff
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_INFO = 3'd1;
  localparam [2:0] ST_SELCHK = 3'd2;
  localparam [2:0] ST_FETCH = 3'd3;

  reg [2:0] state_ff;
  reg fixed_ff;
  reg [3:0] src_ff;
  reg [5:0] num_ff;
  reg [AW-1:0] entry_ff;
  reg [2:0] cnt_ff;
  reg [31:0] vec_ff;
  reg from_fixed_ff;

  wire [19:0] fixed_addr;
  wire fixed_ok;
  wire refuse;
  wire [2:0] step;
  wire [2:0] nxt_cnt;
  wire [AW-1:0] fetch_addr;

  function [AW-1:0] reloc_entry;
    input [AW-1:0] base;
    input [5:0] num;
    begin
      reloc_entry = base + {{(AW-8){1'b0}}, num, 2'b00};
    end
  endfunction

  function reserved_num;
    input [5:0] num;
    begin
      reserved_num = (num != 6'h00) && (num < 6'h08) && (num != 6'h04);
    end
  endfunction

  ivr_fixed_map u_fixed_map (
    // Latched code once busy; the request bus may already carry the next one
    .src((state_ff == ST_IDLE) ? req_src : src_ff),
    .entry_addr(fixed_addr),
    .src_valid(fixed_ok)
  );

  ivr_ch2_source u_ch2_source (
    .clk(clk),
    .rst_n(rst_n),
    .i2c_mode(i2c_mode),
    .ch2_tx_evt(ch2_tx_evt),
    .ch2_rx_evt(ch2_rx_evt),
    .ch2_not_acknowledge(ch2_not_acknowledge),
    .ch2_acknowledge(ch2_acknowledge),
    .ch2_collision_evt(ch2_collision_evt),
    .ch2_start_stop_evt(ch2_start_stop_evt),
    .raise_tx_ff(raise_ch2_tx_ff),
    .raise_rx_ff(raise_ch2_rx_ff),
    .raise_coll_ff(raise_ch2_coll_ff)
  );

  // Relocatable hardware requests obey the enable; fixed sources and software numbers never do
  assign refuse = req_fixed ? !fixed_ok :
                  (req_hw && (!global_int_enable || reserved_num(req_num) ||
                   req_num == `IVR_NUM_BREAK || req_num >= `IVR_NUM_SW_UNMASKED));

  // Odd entries fall back to byte reads, hence the slower sequence
  assign step = entry_ff[0] ? 3'd1 : 3'd2;
  assign nxt_cnt = cnt_ff + step;
  assign fetch_addr = entry_ff + {{(AW-3){1'b0}}, nxt_cnt};

  always @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      req_ready_ff <= 1'b0;
      req_refused_ff <= 1'b0;
      mem_rd_en_ff <= 1'b0;
      mem_addr_ff <= {AW{1'b0}};
      mem_word_ff <= 1'b0;
      info_ff <= 16'h0000;
      clear_req_ff <= 1'b0;
      clear_num_ff <= 6'h00;
      pc_load_ff <= 1'b0;
      pc_value_ff <= {AW{1'b0}};
      id_byte_stb_ff <= 1'b0;
      id_byte_ff <= 8'h00;
      fixed_ff <= 1'b0;
      src_ff <= 4'h0;
      num_ff <= 6'h00;
      entry_ff <= {AW{1'b0}};
      cnt_ff <= 3'd0;
      vec_ff <= 32'h00000000;
      from_fixed_ff <= 1'b0;
    end else begin
      req_refused_ff <= 1'b0;
      mem_rd_en_ff <= 1'b0;
      clear_req_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      id_byte_stb_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          req_ready_ff <= 1'b1;
          if (req_valid && req_ready_ff) begin
            if (refuse) begin
              req_refused_ff <= 1'b1;
            end else begin
              req_ready_ff <= 1'b0;
              fixed_ff <= req_fixed;
              src_ff <= req_src;
              num_ff <= req_num;
              mem_rd_en_ff <= 1'b1;
              mem_addr_ff <= `IVR_INFO_ADDR;
              mem_word_ff <= 1'b1;
              state_ff <= ST_INFO;
            end
          end
        end
        ST_INFO: begin
          if (mem_rd_valid) begin
            info_ff <= mem_rd_data;
            clear_req_ff <= 1'b1;
            clear_num_ff <= num_ff;
            cnt_ff <= 3'd0;
            vec_ff <= 32'h00000000;
            mem_rd_en_ff <= 1'b1;
            if (fixed_ff && src_ff == `IVR_SRC_BREAK) begin
              mem_addr_ff <= `IVR_BREAK_SEL_ADDR;
              mem_word_ff <= 1'b0;
              state_ff <= ST_SELCHK;
            end else if (fixed_ff) begin
              entry_ff <= fixed_addr;
              from_fixed_ff <= 1'b1;
              mem_addr_ff <= fixed_addr;
              mem_word_ff <= 1'b1;
              state_ff <= ST_FETCH;
            end else begin
              entry_ff <= reloc_entry(vector_table_base, num_ff);
              from_fixed_ff <= 1'b0;
              mem_addr_ff <= reloc_entry(vector_table_base, num_ff);
              mem_word_ff <= !vector_table_base[0];
              state_ff <= ST_FETCH;
            end
          end
        end
        ST_SELCHK: begin
          if (mem_rd_valid) begin
            mem_rd_en_ff <= 1'b1;
            state_ff <= ST_FETCH;
            if (mem_rd_data[7:0] == `IVR_BREAK_SEL_VAL) begin
              entry_ff <= reloc_entry(vector_table_base, `IVR_NUM_BREAK);
              from_fixed_ff <= 1'b0;
              mem_addr_ff <= reloc_entry(vector_table_base, `IVR_NUM_BREAK);
              mem_word_ff <= !vector_table_base[0];
            end else begin
              entry_ff <= `IVR_FIX_BREAK;
              from_fixed_ff <= 1'b1;
              mem_addr_ff <= `IVR_FIX_BREAK;
              mem_word_ff <= 1'b1;
            end
          end
        end
        ST_FETCH: begin
          if (mem_rd_valid) begin
            // Lowest address lands in the lowest byte
            if (entry_ff[0]) begin
              vec_ff[cnt_ff[1:0]*8 +: 8] <= mem_rd_data[7:0];
            end else begin
              vec_ff[cnt_ff[1:0]*8 +: 16] <= mem_rd_data;
            end
            if (from_fixed_ff && nxt_cnt == {1'b0, 2'd0} + 3'd4) begin
              id_byte_stb_ff <= 1'b1;
              id_byte_ff <= entry_ff[0] ? mem_rd_data[7:0] : mem_rd_data[15:8];
            end
            if (nxt_cnt >= `IVR_ENTRY_BYTES) begin
              pc_load_ff <= 1'b1;
              if (entry_ff[0]) begin
                // Byte reads: byte 2 is already held, the last read is byte 3
                pc_value_ff <= vec_ff[19:0];
              end else begin
                pc_value_ff <= {mem_rd_data[3:0], vec_ff[15:0]};
              end
              req_ready_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end else begin
              cnt_ff <= nxt_cnt;
              mem_rd_en_ff <= 1'b1;
              mem_addr_ff <= fetch_addr;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ivr_resolver
`default_nettype wire

// File: ivr_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ivr_mem_model (
  input wire logic clk,
  input wire logic rd_en,
  input wire logic [19:0] addr,
  input wire logic break_reloc,
  input wire logic slow,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  logic [19:0] a_ff;
  logic [1:0] wait_ff;
  // Four bytes per entry, byte lanes little-endian
  function automatic [7:0] mb(input [19:0] a);
    mb = a[7:0] ^ a[15:8] ^ 8'h5a;
    if (a == 20'hfffe7 && break_reloc) mb = 8'hff;
    if (a == 20'hfffff) mb = mb | 8'h0f;
  endfunction
  initial begin
    rd_valid = 1'b0;
    rd_data = 16'h0;
    wait_ff = 2'h0;
  end
  always @(posedge clk) begin
    rd_valid <= 1'b0;
    // Idle bus toggles so stale data never looks valid
    rd_data <= ~rd_data;
    if (rd_en) begin
      a_ff <= addr;
      wait_ff <= slow ? 2'h2 : 2'h0;
      rd_valid <= !slow;
      rd_data <= {mb(addr + 20'h1), mb(addr)};
    end else if (wait_ff != 2'h0) begin
      wait_ff <= wait_ff - 2'h1;
      if (wait_ff == 2'h1) begin
        rd_valid <= 1'b1;
        rd_data <= {mb(a_ff + 20'h1), mb(a_ff)};
      end
    end
  end
endmodule // ivr_mem_model
`default_nettype wire

// File: ivr_resolver_props.sv
`timescale 1ns/100ps
`default_nettype none
module ivr_resolver_chk #(parameter AW = 20) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_fixed,
  input wire logic req_hw,
  input wire logic [5:0] req_num,
  input wire logic global_int_enable,
  input wire logic mem_rd_valid,
  input wire logic [15:0] mem_rd_data,
  input wire logic req_ready_ff,
  input wire logic req_refused_ff,
  input wire logic mem_rd_en_ff,
  input wire logic [AW-1:0] mem_addr_ff,
  input wire logic mem_word_ff,
  input wire logic clear_req_ff,
  input wire logic pc_load_ff,
  input wire logic [AW-1:0] pc_value_ff,
  input wire logic id_byte_stb_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] last_rd_ff;
  always @(posedge clk) if (mem_rd_valid) last_rd_ff <= mem_rd_data;
  sequence s_hw_take;
    req_valid && req_ready_ff && !req_fixed && req_hw;
  endsequence
  sequence s_info_rd;
    mem_rd_en_ff && mem_addr_ff == 0 && mem_word_ff;
  endsequence
  masked_refuse_a: assert property ((s_hw_take ##0 !global_int_enable) |=> req_refused_ff && !mem_rd_en_ff)
    else $error("masked request not refused");
  reserved_num_a: assert property ((s_hw_take ##0 (req_num inside {[1:3], [5:7]})) |=> req_refused_ff)
    else $error("reserved number taken");
  sw_take_a: assert property (req_valid && req_ready_ff && !req_fixed && !req_hw |=> s_info_rd)
    else $error("software request not started");
  info_first_a: assert property ($fell(req_ready_ff) |-> s_info_rd)
    else $error("sequence did not begin with info read");
  clear_info_a: assert property (clear_req_ff |-> $past(mem_rd_valid) && $past(mem_addr_ff) == 0)
    else $error("clear not right after info read");
  fixed_id_a: assert property (id_byte_stb_ff |-> pc_load_ff && mem_addr_ff >= 20'hfffdc)
    else $error("id byte outside fixed region");
  pc_high_a: assert property (pc_load_ff && mem_word_ff |-> pc_value_ff[19:16] == last_rd_ff[3:0])
    else $error("routine address high bits wrong");
  load_ready_a: assert property (pc_load_ff |-> req_ready_ff ##1 !pc_load_ff)
    else $error("load pulse or ready wrong");
endmodule // ivr_resolver_chk
bind ivr_resolver ivr_resolver_chk #(.AW(AW)) u_chk (.clk, .rst_n, .req_valid, .req_fixed, .req_hw, .req_num,
  .global_int_enable, .mem_rd_valid, .mem_rd_data, .req_ready_ff, .req_refused_ff, .mem_rd_en_ff, .mem_addr_ff,
  .mem_word_ff, .clear_req_ff, .pc_load_ff, .pc_value_ff, .id_byte_stb_ff);
`default_nettype wire

// File: tb_ivr_resolver.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ivr_resolver;
  logic clk, rst_n, req_valid, req_fixed, req_hw, gie, rd_valid, i2c, break_reloc, slow;
  logic [7:0] idb;
  logic [15:0] info;
  logic [5:0] cnum;
  logic rd_en, ready, refused, pc_load, r_tx, r_rx, r_coll;
  logic [3:0] req_src;
  logic [5:0] req_num, ev;
  logic [15:0] rd_data;
  logic [19:0] base, maddr, pc;
  int bad_count, total_checks;
  ivr_resolver u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_fixed(req_fixed), .req_src(req_src),
    .req_num(req_num), .req_hw(req_hw), .global_int_enable(gie), .vector_table_base(base), .mem_rd_valid(rd_valid),
    .mem_rd_data(rd_data), .i2c_mode(i2c), .ch2_tx_evt(ev[5]), .ch2_rx_evt(ev[4]), .ch2_not_acknowledge(ev[3]),
    .ch2_acknowledge(ev[2]), .ch2_collision_evt(ev[1]), .ch2_start_stop_evt(ev[0]), .req_ready_ff(ready),
    .req_refused_ff(refused), .mem_rd_en_ff(rd_en), .mem_addr_ff(maddr), .mem_word_ff(), .info_ff(info),
    .clear_req_ff(), .clear_num_ff(cnum), .pc_load_ff(pc_load), .pc_value_ff(pc), .id_byte_stb_ff(), .id_byte_ff(idb),
    .raise_ch2_tx_ff(r_tx), .raise_ch2_rx_ff(r_rx), .raise_ch2_coll_ff(r_coll));
  ivr_mem_model u_mem (.clk(clk), .rd_en(rd_en), .addr(maddr), .break_reloc(break_reloc), .slow(slow),
    .rd_valid(rd_valid), .rd_data(rd_data));
  function automatic [7:0] mb(input [19:0] a);
    mb = a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  function automatic [19:0] epc(input [19:0] e);
    logic [7:0] b2;
    b2 = mb(e + 20'h2);
    epc = {b2[3:0], mb(e + 20'h1), mb(e)};
  endfunction
  // High byte of a fixed entry; reserved low nibble of the last byte is all ones
  function automatic [7:0] hb(input [19:0] e);
    hb = mb(e + 20'h3);
    if (e == 20'hffffc) hb = hb | 8'h0f;
  endfunction
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Entered at a falling edge; waits for ready, so it may run back to back
  task automatic req(input logic f, input logic [3:0] s, input logic [5:0] n, input logic hw, input logic ok,
    input logic [19:0] e);
    int i;
    i = 0;
    while (ready !== 1'b1 && i < 50) begin
      @(negedge clk);
      i++;
    end
    chk({19'h0, ready}, 20'h1, "never ready");
    {req_fixed, req_src, req_num, req_hw, req_valid} = {f, s, n, hw, 1'b1};
    @(negedge clk);
    req_valid = 1'b0;
    chk({19'h0, refused}, {19'h0, !ok}, "refusal");
    i = 0;
    while (ok && pc_load !== 1'b1 && i < 60) begin
      @(negedge clk);
      i++;
    end
    if (ok) begin
      chk({19'h0, pc_load}, 20'h1, "no load pulse");
      chk(pc, epc(e), "routine address");
      chk({4'h0, info}, {4'h0, mb(20'h1), mb(20'h0)}, "info word");
      chk({14'h0, cnum}, {14'h0, n}, "cleared number");
    end else begin
      @(negedge clk);
    end
  endtask
  task automatic t_fixed;
    logic [19:0] ent [11];
    ent = '{20'hfffdc, 20'hfffe0, 20'hfffe4, 20'hfffe8, 20'hfffec, 20'hffff0, 20'hffff0, 20'hffff0, 20'hffff4,
      20'hffff8, 20'hffffc};
    for (int k = 0; k < 11; k++) begin
      req(1'b1, k[3:0], 6'h00, 1'b0, 1'b1, ent[k]);
      chk({12'h0, idb}, {12'h0, hb(ent[k])}, "id byte");
    end
    slow = 1'b1;
    req(1'b1, 4'ha, 6'h00, 1'b0, 1'b1, 20'hffffc);
    slow = 1'b0;
    req(1'b1, 4'hb, 6'h00, 1'b0, 1'b0, 20'h0);
  endtask
  task automatic t_break;
    break_reloc = 1'b1;
    req(1'b1, 4'h2, 6'h00, 1'b0, 1'b1, base);
    req(1'b0, 4'h0, 6'h00, 1'b0, 1'b1, base);
    break_reloc = 1'b0;
  endtask
  task automatic t_reloc;
    gie = 1'b0;
    req(1'b0, 4'h0, 6'h04, 1'b0, 1'b1, base + 20'd16);
    req(1'b0, 4'h0, 6'h3f, 1'b0, 1'b1, base + 20'd252);
    req(1'b0, 4'h0, 6'h09, 1'b1, 1'b0, 20'h0);
    gie = 1'b1;
    req(1'b0, 4'h0, 6'h02, 1'b1, 1'b0, 20'h0);
    req(1'b0, 4'h0, 6'h07, 1'b1, 1'b0, 20'h0);
    req(1'b0, 4'h0, 6'h0a, 1'b1, 1'b1, base + 20'd40);
    req(1'b0, 4'h0, 6'h08, 1'b1, 1'b1, base + 20'd32);
    req(1'b0, 4'h0, 6'h09, 1'b1, 1'b1, base + 20'd36);
    req(1'b0, 4'h0, 6'h28, 1'b1, 1'b0, 20'h0);
  endtask
  task automatic t_odd;
    base = 20'h23451;
    req(1'b0, 4'h0, 6'h1f, 1'b1, 1'b1, base + 20'd124);
    base = 20'h12340;
  endtask
  task automatic t_ch2;
    for (int m = 0; m < 2; m++) for (int k = 0; k < 6; k++) begin
      i2c = m[0];
      ev = 6'h01 << k;
      @(negedge clk);
      chk({17'h0, r_tx, r_rx, r_coll}, {17'h0, m ? {ev[3], ev[2], ev[0]} : {ev[5], ev[4], ev[1]}}, "ch2");
    end
    ev = 6'h00;
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is a few hundred cycles; this only catches a hang
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end
  initial begin
    {rst_n, req_valid, req_fixed, req_hw, gie, i2c, break_reloc, slow} = 8'h00;
    req_src = 4'h0;
    req_num = 6'h00;
    ev = 6'h00;
    base = 20'h12340;
    bad_count = 0;
    total_checks = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_fixed;
    t_break;
    t_reloc;
    t_odd;
    t_ch2;
    wrap_up;
  end
endmodule // tb_ivr_resolver
`default_nettype wire
